// ===== include/tepc_pkg.sv
// Shared constants, modes, states and carriers of the timer enable and polarity control.
`default_nettype none

package tepc_pkg;

  // Default counter width of the timer.
  localparam int TEPC_CNT_W = 16;

  // Count value held after reset.
  localparam logic [TEPC_CNT_W-1:0] TEPC_CNT_RST   = 16'h0000;
  // Count value loaded on every reload.
  localparam logic [TEPC_CNT_W-1:0] TEPC_CNT_START = 16'h0001;

  // Operating modes of the timer as seen on the mode port.
  typedef enum logic [2:0] {
    TEPC_M_ONESHOT = 3'h0,
    TEPC_M_CONT    = 3'h1,
    TEPC_M_COUNTER = 3'h2,
    TEPC_M_PWM     = 3'h3,
    TEPC_M_CAPTURE = 3'h4,
    TEPC_M_COMPARE = 3'h5,
    TEPC_M_GATED   = 3'h6,
    TEPC_M_CAPCMP  = 3'h7
  } tepc_mode_e;

  // Run states of the timer, one-hot.
  typedef enum logic [3:0] {
    TEPC_ST_STOPPED = 4'h1,
    TEPC_ST_WAITING = 4'h2,
    TEPC_ST_RUNNING = 4'h4,
    TEPC_ST_DONE    = 4'h8
  } tepc_fsm_e;

  // Software control bits of the timer.
  typedef struct packed {
    logic       count_enable_bit;
    logic       io_polarity_bit;
    tepc_mode_e mode;
  } tepc_cfg_s;

  // State of the input edge detector.
  typedef struct packed {
    logic prev;
    logic primed;
  } tepc_edge_s;

  // Edge and level events derived from the timer input.
  typedef struct packed {
    logic rise;
    logic fall;
    logic sel;
    logic gate_on;
    logic gate_end;
  } tepc_edges_s;

endpackage : tepc_pkg

`default_nettype wire

// ===== hdl/tepc_edge.sv
// Edge and gate event detector on the timer input pin.
`default_nettype none

module tepc_edge
  import tepc_pkg::*;
(
  // Clock and reset.
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Timer input pin and polarity.
  input  wire logic  in_i,
  input  wire logic  pol_i,
  // Derived events.
  output var tepc_edges_s edges_o
);

  tepc_edge_s r;       // Registered state.
  tepc_edge_s next_r;  // Next state.

  // Remember the previous input level; primed blocks a false edge right after reset.
  always_comb begin
    next_r        = r;
    next_r.prev   = in_i;
    next_r.primed = 1'b1;
  end

  // Register the state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Rising and falling edges, plus the edge and gate level chosen by polarity.
  always_comb begin
    edges_o.rise     = r.primed & in_i & ~r.prev;
    edges_o.fall     = r.primed & ~in_i & r.prev;
    // Polarity 0 selects the rising edge, polarity 1 the falling edge.
    edges_o.sel      = pol_i ? edges_o.fall : edges_o.rise;
    // Gate is open while the input is high for polarity 0, low for polarity 1.
    edges_o.gate_on  = in_i ^ pol_i;
    // Gate closes on the edge that leaves the active level.
    edges_o.gate_end = pol_i ? edges_o.rise : edges_o.fall;
  end

endmodule : tepc_edge

`default_nettype wire

// ===== hdl/tepc_timer.sv
// Timer core with count enable and input/output polarity handling per mode.
`default_nettype none

module tepc_timer
  import tepc_pkg::*;
#(
  parameter int CNT_W = TEPC_CNT_W  // Counter width.
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Software control.
  input  wire tepc_cfg_s        cfg_i,
  input  wire logic [CNT_W-1:0] reload_i,
  input  wire logic [CNT_W-1:0] match_i,
  input  wire logic             out_alt_en_i,
  // Timer input pin.
  input  wire logic             timer_input_i,
  // Status.
  output logic      [CNT_W-1:0] count_o,
  output logic      [CNT_W-1:0] capture_o,
  output logic                  capture_valid_o,
  output logic                  interrupt_o,
  // Timer output pin.
  output logic                  timer_output_pin_o,
  output logic                  timer_output_oe_o
);

  // Refuse counter widths that the logic cannot serve.
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  // Whole state of the timer.
  typedef struct packed {
    tepc_fsm_e        fsm;    // Run state.
    logic [CNT_W-1:0] count;  // Running count.
    logic [CNT_W-1:0] cap;    // Last captured count.
    logic             cap_v;  // Capture pulse.
    logic             irq;    // Interrupt pulse.
    logic             pin;    // Timer output level.
    logic             alt_q;  // Output function enable, one cycle late.
  } tepc_state_s;

  tepc_state_s r;          // Registered state.
  tepc_state_s next_r;     // Next state.
  tepc_edges_s edg;        // Input events.
  logic        en;         // Count enable bit.
  logic        pol;        // Polarity bit.
  tepc_mode_e  mode;       // Current mode.
  logic        run;        // Enabled and in the running state.
  logic        tick;       // Count advances this cycle.
  logic        reload_ev;  // Count reaches the reload value.
  logic        match_ev;   // PWM count match.
  logic        cap_ev;     // Capture edge in a capturing mode.
  logic        tog_mode;   // Mode whose output toggles on reload.

  assign en   = cfg_i.count_enable_bit;
  assign pol  = cfg_i.io_polarity_bit;
  assign mode = cfg_i.mode;

  // Input edge detector shared by all modes.
  tepc_edge i_tepc_edge (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_i    (timer_input_i),
    .pol_i   (pol),
    .edges_o (edg)
  );

  // The counter only runs while enabled in the running state.
  assign run = en & (r.fsm == TEPC_ST_RUNNING);

  // Decide when the count advances in each mode.
  always_comb begin
    unique case (mode)
      // Counting on the input edge chosen by polarity.
      TEPC_M_COUNTER: tick = run & edg.sel;
      // Counting while the input sits at its active level.
      TEPC_M_GATED: tick = run & edg.gate_on;
      // All other modes count every clock while running.
      TEPC_M_ONESHOT, TEPC_M_CONT, TEPC_M_PWM, TEPC_M_CAPTURE,
      TEPC_M_COMPARE, TEPC_M_CAPCMP: tick = run;
    endcase
  end

  assign reload_ev = tick & (r.count == reload_i);
  assign match_ev  = tick & (mode == TEPC_M_PWM) & (r.count == match_i);
  assign cap_ev    = run & edg.sel & ((mode == TEPC_M_CAPTURE) | (mode == TEPC_M_CAPCMP));
  assign tog_mode  = (mode == TEPC_M_ONESHOT) | (mode == TEPC_M_CONT) |
                     (mode == TEPC_M_COUNTER) | (mode == TEPC_M_COMPARE);

  // Next state: run control, count, capture, interrupt and output pin.
  always_comb begin
    next_r       = r;
    next_r.cap_v = 1'b0;
    next_r.irq   = 1'b0;
    next_r.alt_q = out_alt_en_i;
    // Run control.
    unique case (r.fsm)
      // Enabling starts the count; capture/compare first waits for an edge.
      TEPC_ST_STOPPED: begin
        if (en) begin
          next_r.fsm = (mode == TEPC_M_CAPCMP) ? TEPC_ST_WAITING : TEPC_ST_RUNNING;
        end
      end
      // The first selected edge starts counting.
      TEPC_ST_WAITING: begin
        if (!en) begin
          next_r.fsm = TEPC_ST_STOPPED;
        end else if (edg.sel) begin
          next_r.fsm = TEPC_ST_RUNNING;
        end
      end
      // One-shot stops after its reload.
      TEPC_ST_RUNNING: begin
        if (!en) begin
          next_r.fsm = TEPC_ST_STOPPED;
        end else if (reload_ev && mode == TEPC_M_ONESHOT) begin
          next_r.fsm = TEPC_ST_DONE;
        end
      end
      // A finished one-shot waits to be disabled.
      TEPC_ST_DONE: begin
        if (!en) begin
          next_r.fsm = TEPC_ST_STOPPED;
        end
      end
      // Illegal codes fall back to stopped.
      default: next_r.fsm = TEPC_ST_STOPPED;
    endcase
    // Count advances or reloads; otherwise it holds.
    if (tick) begin
      next_r.count = reload_ev ? CNT_W'(TEPC_CNT_START) : CNT_W'(r.count + 1'b1);
    end
    // Capture the running count on the selected edge.
    if (cap_ev) begin
      next_r.cap   = r.count;
      next_r.cap_v = 1'b1;
    end
    // Interrupt source per mode.
    unique case (mode)
      TEPC_M_GATED: next_r.irq = run & edg.gate_end;
      TEPC_M_CAPTURE, TEPC_M_CAPCMP: next_r.irq = cap_ev;
      TEPC_M_ONESHOT, TEPC_M_CONT, TEPC_M_COUNTER, TEPC_M_PWM,
      TEPC_M_COMPARE: next_r.irq = reload_ev;
    endcase
    // Output pin; while running it moves only on reload or match events or when the output function turns on.
    if (out_alt_en_i && !r.alt_q) begin
      next_r.pin = pol;
    end else if (!en && (tog_mode || mode == TEPC_M_PWM)) begin
      next_r.pin = pol;
    end else if (reload_ev && mode == TEPC_M_PWM) begin
      next_r.pin = pol;
    end else if (match_ev) begin
      next_r.pin = ~pol;
    end else if (reload_ev && tog_mode) begin
      next_r.pin = ~r.pin;
    end
  end

  // Register the state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r       <= '0;
      r.fsm   <= TEPC_ST_STOPPED;
      r.count <= CNT_W'(TEPC_CNT_RST);
    end else begin
      r <= next_r;
    end
  end

  // Outputs; the pin drives whenever the output function is on.
  assign count_o            = r.count;
  assign capture_o          = r.cap;
  assign capture_valid_o    = r.cap_v;
  assign interrupt_o        = r.irq;
  assign timer_output_pin_o = r.pin;
  assign timer_output_oe_o  = out_alt_en_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A disabled timer keeps its count.
  property p_hold;
    !en |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  // Toggle modes rest at the polarity level while disabled.
  property p_tog_idle;
    (!en && tog_mode && !(out_alt_en_i && !r.alt_q)) |=> timer_output_pin_o == $past(pol);
  endproperty
  a_tog_idle: assert property (p_tog_idle) else $error("idle output not polarity");

  // Counter mode advances by one on the selected edge.
  property p_cnt_edge;
    (run && mode == TEPC_M_COUNTER && edg.sel && count_o != reload_i)
      |=> count_o == CNT_W'($past(count_o) + 1'b1);
  endproperty
  a_cnt_edge: assert property (p_cnt_edge) else $error("counter missed edge");

  // PWM with polarity 0 idles low.
  property p_pwm0;
    (!en && mode == TEPC_M_PWM && !pol) |=> !timer_output_pin_o;
  endproperty
  a_pwm0: assert property (p_pwm0) else $error("pwm idle not low");

  // PWM with polarity 1 goes low on a match.
  property p_pwm1;
    (match_ev && !reload_ev && pol && !(out_alt_en_i && !r.alt_q)) |=> !timer_output_pin_o;
  endproperty
  a_pwm1: assert property (p_pwm1) else $error("pwm match level wrong");

  // A capture edge stores the count it saw.
  property p_capture;
    cap_ev |=> capture_valid_o && capture_o == $past(count_o);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  // Gated mode stops while the gate is closed.
  property p_gate;
    (run && mode == TEPC_M_GATED && !edg.gate_on) |=> $stable(count_o);
  endproperty
  a_gate: assert property (p_gate) else $error("gated count moved");

  // Gated mode interrupts when the gate closes.
  property p_gate_irq;
    (run && mode == TEPC_M_GATED && edg.gate_end) |=> interrupt_o;
  endproperty
  a_gate_irq: assert property (p_gate_irq) else $error("gate end no interrupt");

  // Capture/compare does not count before its first edge.
  property p_wait;
    (r.fsm == TEPC_ST_WAITING) |=> $stable(count_o) && !capture_valid_o;
  endproperty
  a_wait: assert property (p_wait) else $error("counted before start edge");

  // Turning the output function on shows the polarity next cycle.
  property p_alt;
    (out_alt_en_i && !r.alt_q) |=> timer_output_pin_o == $past(pol);
  endproperty
  a_alt: assert property (p_alt) else $error("pin did not take polarity");

  // While running, a polarity change alone leaves the pin alone.
  property p_pol_run;
    (run && $changed(pol) && !reload_ev && !match_ev && !(out_alt_en_i && !r.alt_q))
      |=> $stable(timer_output_pin_o);
  endproperty
  a_pol_run: assert property (p_pol_run) else $error("pin followed polarity");

endmodule : tepc_timer

`default_nettype wire

// ===== verification/tepc_pin_model.sv
// Model of the external logic that drives the timer input pin.
`default_nettype none

module tepc_pin_model (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Requested level and the pin it drives.
  input  wire logic level_i,
  output var logic  pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // The pin follows the request one edge later, so it is synchronous to the clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= level_i;
    end
  end
endmodule : tepc_pin_model

`default_nettype wire

// ===== verification/tepc_timer_bench.sv
// Self-checking bench of the timer enable and polarity control.
`default_nettype none

module tepc_timer_bench
  import tepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int W = 8;            // Reduced counter width.
  logic          clk_i  = 1'b0;    // System clock.
  logic          rst_i  = 1'b1;    // Reset, held at start.
  tepc_cfg_s     cfg    = '0;      // Software control bits.
  logic [W-1:0]  reload = 8'hff;   // Terminal count.
  logic [W-1:0]  match  = 8'h03;   // PWM match value.
  logic          alt_en = 1'b0;    // Output function enable.
  logic          level  = 1'b0;    // Level asked of the pin model.
  logic          tin;              // Timer input pin.
  logic [W-1:0]  count;            // Running count.
  logic [W-1:0]  cap;              // Captured count.
  logic          cap_v;            // Capture pulse.
  logic          irq;              // Interrupt pulse.
  logic          pin;              // Timer output pin.
  logic          oe;               // Output enable of the pin.
  int            mismatches = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  tepc_pin_model i_tepc_pin_model (.clk_i(clk_i), .rst_i(rst_i), .level_i(level), .pin_o(tin));

  tepc_timer #(.CNT_W(W)) i_tepc_timer (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .reload_i(reload), .match_i(match),
    .out_alt_en_i(alt_en), .timer_input_i(tin), .count_o(count), .capture_o(cap),
    .capture_valid_o(cap_v), .interrupt_o(irq), .timer_output_pin_o(pin),
    .timer_output_oe_o(oe));

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Compares a seen value with the expected one.
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Advances n edges and samples just after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // Drives the control bits at a rising edge.
  task automatic set_cfg(input logic en, input logic p, input tepc_mode_e m);
    @(posedge clk_i);
    cfg <= '{en, p, m};
  endtask : set_cfg

  // Asks the pin model for a new input level.
  task automatic set_level(input logic v);
    @(posedge clk_i);
    level <= v;
  endtask : set_level

  // Waits for an interrupt (0), a capture (1) or the pin at want (2).
  task automatic wait_for(input int sel, input int n, input logic want, output logic hit);
    hit = 1'b0;
    for (int k = 0; k < n && !hit; k++) begin
      step(1);
      hit = (sel == 0) ? irq === 1'b1 : (sel == 1) ? cap_v === 1'b1 : pin === want;
    end
  endtask : wait_for

  // Stops the timer, parks the input at the polarity level, then enables.
  task automatic arm(input logic p, input tepc_mode_e m);
    set_cfg(1'b0, p, m);
    set_level(p);
    step(3);
    set_cfg(1'b1, p, m);
  endtask : arm

  // Reset values, then the output function forces the pin to polarity.
  task automatic t_reset();
    check(count, 8'h00);
    check(pin, 8'h00);
    check(oe, 8'h00);
    set_cfg(1'b0, 1'b1, TEPC_M_CAPTURE);
    alt_en <= 1'b1;
    step(1);
    check(oe, 8'h01);
    check(pin, 8'h01);
  endtask : t_reset

  // Count runs one per clock while enabled and freezes when disabled.
  task automatic t_hold();
    logic [W-1:0] c;
    @(posedge clk_i);
    reload <= 8'hff;
    arm(1'b0, TEPC_M_CONT);
    step(4);
    c = count;
    step(2);
    check(count, c + 8'h02);
    set_cfg(1'b0, 1'b0, TEPC_M_CONT);
    step(2);
    c = count;
    step(5);
    check(count, c);
  endtask : t_hold

  // Toggle modes: idle at polarity, late polarity write, toggle on reload.
  task automatic t_toggle();
    tepc_mode_e m [3] = '{TEPC_M_ONESHOT, TEPC_M_COMPARE, TEPC_M_CONT};
    logic       hit;
    // A mid-run reset clears the count left by earlier scenarios.
    @(posedge clk_i);
    reload <= 8'h03;
    rst_i  <= 1'b1;
    step(2);
    check(count, 8'h00);
    check(pin, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      set_cfg(1'b0, k[0], m[k]);
      step(2);
      check(pin, k[0]);
      set_cfg(1'b1, k[0], m[k]);
      set_cfg(1'b1, ~k[0], m[k]);
      step(1);
      check(pin, k[0]);
      wait_for(0, 12, 1'b0, hit);
      check(hit, 8'h01);
      check(pin, {7'h00, ~k[0]});
    end
  endtask : t_toggle

  // PWM: idle at polarity, inverse on match, polarity on reload.
  task automatic t_pwm();
    logic hit;
    @(posedge clk_i);
    reload <= 8'h08;
    for (int k = 0; k < 2; k++) begin
      set_cfg(1'b0, k[0], TEPC_M_PWM);
      step(2);
      check(pin, k[0]);
      set_cfg(1'b1, k[0], TEPC_M_PWM);
      wait_for(2, 20, ~k[0], hit);
      check(hit, 8'h01);
      wait_for(2, 20, k[0], hit);
      check(hit, 8'h01);
    end
  endtask : t_pwm

  // Counter, capture, gated and capture/compare edge selection per polarity.
  task automatic t_edges();
    logic [W-1:0] c;
    logic         hit;
    @(posedge clk_i);
    reload <= 8'hff;
    for (int k = 0; k < 2; k++) begin
      arm(k[0], TEPC_M_COUNTER);
      step(4);
      c = count;
      set_level(~k[0]);
      step(4);
      check(count, c + 8'h01);
      set_level(k[0]);
      step(4);
      check(count, c + 8'h01);
      arm(k[0], TEPC_M_CAPTURE);
      step(4);
      set_level(~k[0]);
      wait_for(1, 6, 1'b1, hit);
      check(hit, 8'h01);
      check(cap, count - 8'h01);
      set_level(k[0]);
      wait_for(1, 6, 1'b1, hit);
      check(hit, 8'h00);
      arm(k[0], TEPC_M_GATED);
      step(3);
      c = count;
      step(3);
      check(count, c);
      set_level(~k[0]);
      step(4);
      c = count;
      step(2);
      check(count, c + 8'h02);
      set_level(k[0]);
      wait_for(0, 6, 1'b1, hit);
      check(hit, 8'h01);
      arm(k[0], TEPC_M_CAPCMP);
      step(3);
      c = count;
      step(3);
      check(count, c);
      set_level(~k[0]);
      wait_for(1, 5, 1'b1, hit);
      check(hit, 8'h00);
      c = count;
      step(2);
      check(count, c + 8'h02);
      set_level(k[0]);
      step(3);
      set_level(~k[0]);
      wait_for(1, 6, 1'b1, hit);
      check(hit, 8'h01);
    end
  endtask : t_edges

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    t_reset();
    t_hold();
    t_toggle();
    t_pwm();
    t_edges();
    close_out();
  end
endmodule : tepc_timer_bench

`default_nettype wire
